// >>> pkg/rts_pkg.sv
// package: constants for the resistive touch scan control block
package rts_pkg;
    localparam int          SAMPLE_W      = 10;
    localparam logic [2:0]  SEL_AXIS_A    = 3'h6;     // select two high, one high, zero low
    localparam logic [2:0]  SEL_AXIS_B    = 3'h1;     // select two low, one low, zero high
    localparam logic [9:0]  NO_PRESS_LIM  = 10'h3a0;
    localparam logic [9:0]  CODE_MAX      = 10'h3ff;
    localparam int          CLK_MHZ       = 50;
    localparam int          SETTLE_US     = 20;
    localparam int          SETTLE_CYC    = SETTLE_US * CLK_MHZ;
endpackage

// >>> hw/rts_settle_timer.sv
// settling timer: counts a programmed interval after each restart
`timescale 1ns/1ps
module rts_settle_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             start_i,
    input  wire logic [CNT_W-1:0] len_i,
    output logic                  done_o
);
    if (CNT_W < 1) begin : g_bad_width
        $error("counter width out of range");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             done_reg;
    logic             done_next;

    always_comb begin
        cnt_next  = cnt_reg;
        done_next = done_reg;
        if (start_i) begin
            cnt_next  = len_i;
            done_next = 1'b0;
        end else if (cnt_reg > 1) begin
            cnt_next = cnt_reg - 1'b1;
        end else if (!done_reg) begin
            cnt_next  = '0;
            done_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;
endmodule // rts_settle_timer

// >>> hw/rts_scan_ctrl.sv
// top: four-wire resistive panel scan sequencer and touch classifier
// What this block does
// R01 - axis a: pattern 110, sample channel zero
// R02 - axis b: pattern 001, sample channel one
// R03 - only the two axis patterns appear
// R04 - axes measured one at a time, swapped
// R05 - samples are unsigned ten-bit codes
// R06 - above 0x3a0 is no press, nothing forwarded
// R07 - wait settling interval; no conversion started before it ends
`timescale 1ns/1ps
module rts_scan_ctrl #(
    parameter int CNT_W      = 16,
    parameter int SETTLE_CYC = rts_pkg::SETTLE_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        scan_en_i,
    input  wire logic [CNT_W-1:0] settle_len_i,
    output logic             axis_select_0_o,
    output logic             axis_select_1_o,
    output logic             axis_select_2_o,
    output logic             conv_start_o,
    output logic             conv_channel_o,
    input  wire logic        conv_done_i,
    input  wire logic [9:0]  conv_data_i,
    output logic [9:0]       pos_a_o,
    output logic [9:0]       pos_b_o,
    output logic             pos_valid_o,
    output logic             pen_down_o
);
    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > 30) begin : g_bad_width
        $error("counter width out of range");
    end
    if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << CNT_W)) begin : g_bad_settle
        $error("settle count does not fit counter");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE_A,
        ST_CONV_A,
        ST_SETTLE_B,
        ST_CONV_B
    } rts_state_t;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    rts_state_t  state_reg;
    rts_state_t  state_next;
    logic [2:0]  sel_reg;
    logic [2:0]  sel_next;
    logic        start_reg;
    logic        start_next;
    logic        chan_reg;
    logic        chan_next;
    logic [9:0]  samp_a_reg;
    logic [9:0]  samp_a_next;
    logic [9:0]  pos_a_reg;
    logic [9:0]  pos_a_next;
    logic [9:0]  pos_b_reg;
    logic [9:0]  pos_b_next;
    logic        valid_reg;
    logic        valid_next;
    logic        pen_reg;
    logic        pen_next;
    logic        tmr_start;
    logic        settled;
    logic [CNT_W-1:0] settle_len;

    assign settle_len = (settle_len_i == '0) ? CNT_W'(SETTLE_CYC) : settle_len_i;

    rts_settle_timer #(
        .CNT_W (CNT_W)
    ) u_settle (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .start_i (tmr_start),
        .len_i   (settle_len),
        .done_o  (settled)
    );

    always_comb begin
        state_next  = state_reg;
        sel_next    = sel_reg;
        start_next  = 1'b0;
        chan_next   = chan_reg;
        samp_a_next = samp_a_reg;
        pos_a_next  = pos_a_reg;
        pos_b_next  = pos_b_reg;
        valid_next  = 1'b0;
        pen_next    = pen_reg;
        tmr_start   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (scan_en_i) begin
                    sel_next   = rts_pkg::SEL_AXIS_A;              // [R01] [R04]
                    chan_next  = 1'b0;                             // [R01]
                    tmr_start  = 1'b1;                             // [R07]
                    state_next = ST_SETTLE_A;
                end
            end
            ST_SETTLE_A: begin
                if (settled && !tmr_start) begin
                    start_next = 1'b1;                             // [R07]
                    state_next = ST_CONV_A;
                end
            end
            ST_CONV_A: begin
                if (conv_done_i) begin
                    samp_a_next = conv_data_i;                     // [R05]
                    sel_next    = rts_pkg::SEL_AXIS_B;             // [R02] [R04]
                    chan_next   = 1'b1;                            // [R02]
                    tmr_start   = 1'b1;                            // [R07]
                    state_next  = ST_SETTLE_B;
                end
            end
            ST_SETTLE_B: begin
                if (settled && !tmr_start) begin
                    start_next = 1'b1;                             // [R07]
                    state_next = ST_CONV_B;
                end
            end
            ST_CONV_B: begin
                if (conv_done_i) begin
                    if (samp_a_reg > rts_pkg::NO_PRESS_LIM ||
                        conv_data_i > rts_pkg::NO_PRESS_LIM) begin
                        pen_next = 1'b0;                           // [R06]
                    end else begin
                        pen_next   = 1'b1;
                        pos_a_next = samp_a_reg;                   // [R06]
                        pos_b_next = conv_data_i;
                        valid_next = 1'b1;
                    end
                    if (scan_en_i) begin
                        sel_next   = rts_pkg::SEL_AXIS_A;          // [R04]
                        chan_next  = 1'b0;
                        tmr_start  = 1'b1;
                        state_next = ST_SETTLE_A;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                sel_next   = rts_pkg::SEL_AXIS_A;                  // [R03]
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg  <= ST_IDLE;
            sel_reg    <= rts_pkg::SEL_AXIS_A;                     // [R03]
            start_reg  <= 1'b0;
            chan_reg   <= 1'b0;
            samp_a_reg <= '0;
            pos_a_reg  <= '0;
            pos_b_reg  <= '0;
            valid_reg  <= 1'b0;
            pen_reg    <= 1'b0;
        end else begin
            state_reg  <= state_next;
            sel_reg    <= sel_next;
            start_reg  <= start_next;
            chan_reg   <= chan_next;
            samp_a_reg <= samp_a_next;
            pos_a_reg  <= pos_a_next;
            pos_b_reg  <= pos_b_next;
            valid_reg  <= valid_next;
            pen_reg    <= pen_next;
        end
    end

    assign axis_select_0_o = sel_reg[0];
    assign axis_select_1_o = sel_reg[1];
    assign axis_select_2_o = sel_reg[2];
    assign conv_start_o    = start_reg;
    assign conv_channel_o  = chan_reg;
    assign pos_a_o         = pos_a_reg;
    assign pos_b_o         = pos_b_reg;
    assign pos_valid_o     = valid_reg;
    assign pen_down_o      = pen_reg;

    // ---------------------------------------------------------------
    // settle witness: cycles since the last timer restart
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] held_reg;
    logic [CNT_W-1:0] held_next;
    logic [CNT_W-1:0] need_reg;
    logic [CNT_W-1:0] need_next;

    always_comb begin
        held_next = held_reg;
        need_next = need_reg;
        if (tmr_start) begin
            held_next = '0;
            need_next = settle_len;                                // [R07]
        end else if (held_reg != '1) begin
            held_next = held_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held_reg <= '1;
            need_reg <= '0;
        end else begin
            held_reg <= held_next;
            need_reg <= need_next;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_conv_a;
        conv_start_o && !conv_channel_o;
    endsequence
    sequence s_conv_b;
        conv_start_o && conv_channel_o;
    endsequence

    property p_sel_legal;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (sel_reg == rts_pkg::SEL_AXIS_A) || (sel_reg == rts_pkg::SEL_AXIS_B);
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("illegal select pattern"); // [R03]

    property p_axis_a;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_conv_a |-> (sel_reg == rts_pkg::SEL_AXIS_A);
    endproperty
    a_axis_a: assert property (p_axis_a) else $error("axis a pattern wrong at conversion"); // [R01]

    property p_axis_b;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_conv_b |-> (sel_reg == rts_pkg::SEL_AXIS_B);
    endproperty
    a_axis_b: assert property (p_axis_b) else $error("axis b pattern wrong at conversion"); // [R02]

    property p_settle;
        @(posedge mclk_i) disable iff (!rst_n_i)
        conv_start_o |-> $stable(sel_reg) && (held_reg >= need_reg);
    endproperty
    a_settle: assert property (p_settle) else $error("conversion started without settling"); // [R07]

    property p_no_press;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (state_reg == ST_CONV_B && conv_done_i &&
         (samp_a_reg > rts_pkg::NO_PRESS_LIM || conv_data_i > rts_pkg::NO_PRESS_LIM))
        |=> !pos_valid_o && !pen_down_o;
    endproperty
    a_no_press: assert property (p_no_press) else $error("no-press sample forwarded"); // [R06]

    property p_valid_range;
        @(posedge mclk_i) disable iff (!rst_n_i)
        pos_valid_o |-> pos_a_o <= rts_pkg::NO_PRESS_LIM && pos_b_o <= rts_pkg::NO_PRESS_LIM && pen_down_o;
    endproperty
    a_valid_range: assert property (p_valid_range) else $error("forwarded position above limit"); // [R06]

    property p_swap;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (state_reg == ST_CONV_A && conv_done_i) |=> sel_reg == rts_pkg::SEL_AXIS_B && conv_channel_o;
    endproperty
    a_swap: assert property (p_swap) else $error("axes not swapped after first sample"); // [R04]
endmodule // rts_scan_ctrl

// >>> tb/rts_conv_model.sv
// converter model: answers each conversion request after a chosen delay
`timescale 1ns/1ps
module rts_conv_model (
    input  wire logic       mclk_i,
    input  wire logic       conv_start_i,
    input  wire logic       conv_channel_i,
    input  wire logic [9:0] data0_i,
    input  wire logic [9:0] data1_i,
    input  wire logic [3:0] delay_i,
    output logic            conv_done_o,
    output logic [9:0]      conv_data_o
);
    logic       busy_reg = 1'b0;
    logic       chan_reg = 1'b0;
    logic [3:0] cnt_reg  = 4'h0;
    initial conv_done_o = 1'b0;
    initial conv_data_o = 10'h155;
    // ------------------------------------------------------------
    // answer path, data bus toggles while no result is offered
    // ------------------------------------------------------------
    always @(negedge mclk_i) begin
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o;
        if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) begin
                conv_done_o <= 1'b1;
                conv_data_o <= chan_reg ? data1_i : data0_i;
                busy_reg    <= 1'b0;
            end
        end
        if (conv_start_i === 1'b1) begin
            busy_reg <= 1'b1;
            cnt_reg  <= delay_i;
            chan_reg <= conv_channel_i;
        end
    end
endmodule // rts_conv_model

// >>> tb/tb.sv
// testbench: self-checking bench for the resistive touch scan control block
`timescale 1ns/1ps
module tb;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        scan_en_i = 1'b0;
    logic [15:0] settle_len_i = 16'h0004;
    logic        s0, s1, s2, conv_start_o, conv_channel_o, conv_done_i, pos_valid_o, pen_down_o;
    logic [9:0]  conv_data_i, pos_a_o, pos_b_o;
    logic [9:0]  d0 = 10'h000, d1 = 10'h000, exp_pa = 10'h000, exp_pb = 10'h000;
    logic [3:0]  dly = 4'h1;
    logic [2:0]  sel, prev_sel = 3'h6;
    logic        exp_ch = 1'b0;
    int          err_count = 0, total_checks = 0, cyc = 0, pv_cnt = 0, st_cnt = 0, settle_cnt = 0, base;
    logic [15:0] lens [4] = '{16'h0000, 16'h0001, 16'h0007, 16'h000c};
    logic [19:0] corner [5] = '{{10'h050, 10'h3a0}, {10'h3a1, 10'h100}, {10'h100, 10'h3a1},
                                {10'h3ff, 10'h3ff}, {10'h000, 10'h000}};
    assign sel = {s2, s1, s0};

    rts_scan_ctrl #(.CNT_W(16), .SETTLE_CYC(4)) rts_scan_ctrl_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .scan_en_i(scan_en_i), .settle_len_i(settle_len_i), .axis_select_0_o(s0), .axis_select_1_o(s1),
        .axis_select_2_o(s2), .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .pos_a_o(pos_a_o), .pos_b_o(pos_b_o),
        .pos_valid_o(pos_valid_o), .pen_down_o(pen_down_o));
    rts_conv_model rts_conv_model_i (.mclk_i(mclk_i), .conv_start_i(conv_start_o),
        .conv_channel_i(conv_channel_o), .data0_i(d0), .data1_i(d1), .delay_i(dly),
        .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));

    initial forever #10 mclk_i = ~mclk_i;

    function automatic int eff_settle();
        return (settle_len_i == 16'h0000) ? 4 : int'(settle_len_i);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitor: patterns, order, settling, pulse counts, timeout
    // ------------------------------------------------------------
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            give_verdict();
        end else if (rst_n_i) begin
            chk({15'h0, sel == rts_pkg::SEL_AXIS_A || sel == rts_pkg::SEL_AXIS_B}, 16'h0001);
            settle_cnt = (sel != prev_sel) ? 0 : settle_cnt + 1;
            prev_sel = sel;
            if (pos_valid_o === 1'b1) pv_cnt++;
            if (conv_start_o === 1'b1) begin
                st_cnt++;
                chk({15'h0, conv_channel_o}, {15'h0, exp_ch});
                chk({13'h0, sel}, {13'h0, exp_ch ? rts_pkg::SEL_AXIS_B : rts_pkg::SEL_AXIS_A});
                chk({15'h0, settle_cnt >= eff_settle()}, 16'h0001);
                exp_ch = ~exp_ch;
            end
        end
    end

    task automatic run_pair(input logic [9:0] a, input logic [9:0] b);
        int  pbase;
        int  n;
        logic ok;
        pbase = pv_cnt;
        n = 0;
        ok = (a <= rts_pkg::NO_PRESS_LIM) && (b <= rts_pkg::NO_PRESS_LIM);
        d0 = a;
        d1 = b;
        dly = 4'($urandom_range(0, 8));
        repeat (2) begin
            @(posedge mclk_i);
            while (conv_done_i !== 1'b1 && n < 200) begin
                @(posedge mclk_i);
                n++;
            end
        end
        chk({15'h0, n >= 200}, 16'h0000);
        @(posedge mclk_i);
        @(negedge mclk_i);
        if (ok) begin
            exp_pa = a;
            exp_pb = b;
        end
        chk(16'(pv_cnt - pbase), {15'h0, ok});
        chk({15'h0, pen_down_o}, {15'h0, ok});
        chk({6'h0, pos_a_o}, {6'h0, exp_pa});
        chk({6'h0, pos_b_o}, {6'h0, exp_pb});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h116a));
        @(negedge mclk_i);
        chk({13'h0, sel}, {13'h0, rts_pkg::SEL_AXIS_A});
        chk({12'h0, conv_start_o, pos_valid_o, pen_down_o, conv_channel_o}, 16'h0000);
        @(negedge mclk_i);
        rst_n_i = 1'b1;
        foreach (lens[i]) begin
            settle_len_i = lens[i];
            scan_en_i = 1'b1;
            foreach (corner[j]) run_pair(corner[j][19:10], corner[j][9:0]);
            repeat (6) run_pair(10'($urandom_range(0, 10'h3c0)), 10'($urandom_range(0, 10'h3c0)));
            scan_en_i = 1'b0;
            repeat (80) @(negedge mclk_i);
            base = st_cnt;
            repeat (40) @(negedge mclk_i);
            chk(16'(st_cnt - base), 16'h0000);
        end
        give_verdict();
    end
endmodule // tb
